// >>> rcs_defines.svh
// Constant values for the drive run-command sequencer.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// Master clock rate in hertz.
`define RCS_CLK_HZ 20000000
// Least time a push-button command must be held, in milliseconds.
`define RCS_MIN_PRESS_MS 1
// Cycles in one millisecond and in one tenth of a second.
`define RCS_MS_CYCLES (`RCS_CLK_HZ / 1000)
`define RCS_PRESS_CYCLES (`RCS_MIN_PRESS_MS * `RCS_MS_CYCLES)
`define RCS_TENTH_CYCLES (`RCS_CLK_HZ / 10)

// Multi-function terminal function codes.
`define RCS_FUNC_RUN_ENABLE 6'h0D
`define RCS_FUNC_THREE_WIRE 6'h0E

// Gating selection codes.
`define RCS_GATE_ALWAYS 1'h0
`define RCS_GATE_INPUT 1'h1

// Safe-stop mode codes.
`define RCS_STOP_FREE_RUN 2'h0
`define RCS_STOP_QUICK 2'h1
`define RCS_STOP_QUICK_RESUME 2'h2

// Control mode code that allows dwell sequencing.
`define RCS_CTRL_VF 3'h0

// Reset values and limits of settings, and the zero frequency: frequency in 0.01 Hz, times in 0.1 s.
`define RCS_DWELL_FREQ_RST 16'h01F4
`define RCS_DWELL_TIME_RST 10'h000
`define RCS_DWELL_TIME_MAX 10'h258
`define RCS_QSTOP_TIME_RST 13'h0032
`define RCS_QSTOP_TIME_MAX 13'h1770
`define RCS_FREQ_ZERO 16'h0000

`endif

// >>> rcs_pkg.sv
// Types shared by the drive run-command sequencer.
package rcs_pkg;

  typedef enum logic [3:0]
  {
    RCS_IDLE,
    RCS_ACC_RAMP,
    RCS_ACC_HOLD,
    RCS_RUN,
    RCS_DEC_RAMP,
    RCS_DEC_HOLD,
    RCS_DECEL,
    RCS_QSTOP,
    RCS_COAST
  } rcs_state_t;

  typedef struct packed
  {
    logic [5:0]  stop_term_func;
    logic [5:0]  run_en_term_func;
    logic        gating_by_input;
    logic [1:0]  stop_mode;
    logic [2:0]  control_mode;
    logic [15:0] acc_dwell_freq;
    logic [9:0]  acc_dwell_time;
    logic [15:0] dec_dwell_freq;
    logic [9:0]  dec_dwell_time;
    logic [15:0] start_freq;
    logic [15:0] max_freq;
    logic [12:0] qstop_time;
  } rcs_cfg_t;

  typedef struct packed
  {
    logic run_active;
    logic reverse_dir;
    logic output_block;
    logic quick_stop_active;
    logic acc_dwell_active;
    logic dec_dwell_active;
    logic need_fresh_cmd;
  } rcs_status_t;

endpackage

// >>> rcs_input_filter.sv
// Two-stage synchroniser followed by a stable-time filter for one terminal.
module rcs_input_filter
  import rcs_pkg::*;
#(
  parameter int STABLE_CYCLES = 20000
)
(
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_b,
  // Terminal pin and filtered level.
  input  wire logic pin,
  output logic      level
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_level;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // A new level is taken only after it has stood for the whole filter time.
  always_comb
  begin
    next_count = '0;
    next_level = level;
    if (sync_b != level)
    begin
      if (count == LAST)
        next_level = sync_b;
      else
        next_count = count + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= '0;
      level <= 1'b0;
    end
    else
    begin
      count <= next_count;
      level <= next_level;
    end
  end

endmodule

// >>> rcs_hold_timer.sv
// Hold timer counting whole tenths of a second after a start pulse.
module rcs_hold_timer
  import rcs_pkg::*;
#(
  parameter int TENTH_CYCLES = 2000000
)
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Start pulse with duration in tenths of a second.
  input  wire logic       start,
  input  wire logic [9:0] tenths,
  // Completion pulse.
  output logic            done
);

  localparam int PW = $clog2(TENTH_CYCLES + 1);
  localparam logic [PW-1:0] PLAST = PW'(TENTH_CYCLES - 1);

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [9:0]    left;
  logic [9:0]    next_left;
  logic          busy;
  logic          next_busy;
  logic          next_done;

  always_comb
  begin
    next_pre  = pre;
    next_left = left;
    next_busy = busy;
    next_done = 1'b0;
    if (start)
    begin
      next_pre  = '0;
      next_left = tenths;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      if (pre == PLAST)
      begin
        next_pre = '0;
        if (left <= 10'h001)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
        else
          next_left = left - 10'h001;
      end
      else
        next_pre = pre + PW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre  <= '0;
      left <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      pre  <= next_pre;
      left <= next_left;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule

// >>> rcs_sequencer.sv
// Run-command sequencer: three-wire latch, run-enable gating and dwell holds.
//
// Behaviour
// - Three-wire latches momentary forward or reverse button.
// - Forward and reverse together stop the drive.
// - Terminal code 13 is the run-enable input.
// - Gating setting 0 off, 1 input dependent.
// - Gated: accept run only with enable asserted.
// - Safe-stop mode 0 to 2, default free-run.
// - Free-run: block output when enable drops.
// - Modes 1 and 2: enable loss decelerates on quick-stop time.
// - Quick stop: restart needs fresh run command.
// - Quick-stop resume: restart on enable with command.
// - Dwell only in V/F control mode.
// - Run: ramp to dwell, hold, then accelerate.
// - Stop: ramp to dwell, hold, then stop.
// - Dwell defaults 5.00 Hz, 0 s, clamped ranges.
// - Skip dwell when time or frequency zero.
// - Only the first acceleration dwell per run.
// - No deceleration dwell on lowered reference.
`include "rcs_defines.svh"

module rcs_sequencer
  import rcs_pkg::*;
#(
  parameter int PRESS_CYCLES = `RCS_PRESS_CYCLES,
  parameter int TENTH_CYCLES = `RCS_TENTH_CYCLES
)
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Terminal pins.
  input  wire logic        forward_run_cmd,
  input  wire logic        reverse_run_cmd,
  input  wire logic        stop_term,
  input  wire logic        run_enable_term,
  // Settings.
  input  wire rcs_cfg_t    cfg,
  // Frequency reference in and ramp output feedback, 0.01 Hz units.
  input  wire logic [15:0] target_freq,
  input  wire logic [15:0] out_freq,
  // Sequencer results.
  output rcs_status_t      status,
  output logic [15:0]      freq_ref,
  output logic [12:0]      decel_time
);

  logic        fwd_f;
  logic        rev_f;
  logic        stop_f;
  logic        en_f;
  logic        fwd_d;
  logic        rev_d;
  logic        fwd_latch;
  logic        rev_latch;
  logic        next_fwd_latch;
  logic        next_rev_latch;
  logic        three_wire;
  logic        both_cmd;
  logic        run_cmd;
  logic        want_rev;
  logic        gate_on;
  logic        enable_ok;
  logic        vf_mode;
  logic [15:0] acc_freq;
  logic [15:0] dec_freq;
  logic [9:0]  acc_time;
  logic [9:0]  dec_time;
  logic        acc_dwell_ok;
  logic        dec_dwell_ok;
  logic        acc_done;
  logic        dec_done;
  logic        running;

  rcs_state_t  state;
  rcs_state_t  next_state;
  logic        acc_spent;
  logic        next_acc_spent;
  logic        need_fresh;
  logic        next_need_fresh;
  logic        acc_start;
  logic        next_acc_start;
  logic        dec_start;
  logic        next_dec_start;
  rcs_status_t next_status;
  logic [15:0] next_freq_ref;
  logic [12:0] next_decel_time;

  // Short presses are filtered out rather than half-taken.
  rcs_input_filter #(.STABLE_CYCLES(PRESS_CYCLES)) u_fwd_filter
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   (forward_run_cmd),
    .level (fwd_f)
  );

  rcs_input_filter #(.STABLE_CYCLES(PRESS_CYCLES)) u_rev_filter
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   (reverse_run_cmd),
    .level (rev_f)
  );

  rcs_input_filter #(.STABLE_CYCLES(PRESS_CYCLES)) u_stop_filter
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   (stop_term),
    .level (stop_f)
  );

  rcs_input_filter #(.STABLE_CYCLES(PRESS_CYCLES)) u_en_filter
  (
    .mclk  (mclk),
    .rst_b (rst_b),
    .pin   (run_enable_term),
    .level (en_f)
  );

  rcs_hold_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_acc_timer
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .start  (acc_start),
    .tenths (acc_time),
    .done   (acc_done)
  );

  rcs_hold_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_dec_timer
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .start  (dec_start),
    .tenths (dec_time),
    .done   (dec_done)
  );

  function automatic logic [15:0] clamp_freq(input logic [15:0] f, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = f;
    if (r < lo)
      r = lo;
    if (r > hi)
      r = hi;
    return r;
  endfunction

  function automatic logic [9:0] limit_time(input logic [9:0] t);
    return (t > `RCS_DWELL_TIME_MAX) ? `RCS_DWELL_TIME_MAX : t;
  endfunction

  // Command decoding and run-enable gating.
  always_comb
  begin
    three_wire = (cfg.stop_term_func == `RCS_FUNC_THREE_WIRE);
    both_cmd   = fwd_f & rev_f;
    next_fwd_latch = fwd_latch;
    next_rev_latch = rev_latch;
    if (!three_wire || both_cmd || !stop_f)
    begin
      next_fwd_latch = 1'b0;
      next_rev_latch = 1'b0;
    end
    else if (fwd_f && !fwd_d)
    begin
      next_fwd_latch = 1'b1;
      next_rev_latch = 1'b0;
    end
    else if (rev_f && !rev_d)
    begin
      next_fwd_latch = 1'b0;
      next_rev_latch = 1'b1;
    end
    if (three_wire)
    begin
      run_cmd  = (fwd_latch | rev_latch) & ~both_cmd & stop_f;
      want_rev = rev_latch;
    end
    else
    begin
      run_cmd  = fwd_f ^ rev_f;
      want_rev = rev_f;
    end
    gate_on   = cfg.gating_by_input == `RCS_GATE_INPUT && cfg.run_en_term_func == `RCS_FUNC_RUN_ENABLE;
    enable_ok = !gate_on || en_f;
  end

  // Dwell qualification.
  always_comb
  begin
    vf_mode      = (cfg.control_mode == `RCS_CTRL_VF);
    acc_freq     = clamp_freq(cfg.acc_dwell_freq, cfg.start_freq, cfg.max_freq);
    dec_freq     = clamp_freq(cfg.dec_dwell_freq, cfg.start_freq, cfg.max_freq);
    acc_time     = limit_time(cfg.acc_dwell_time);
    dec_time     = limit_time(cfg.dec_dwell_time);
    acc_dwell_ok = vf_mode && (acc_time != 10'h000) && (cfg.acc_dwell_freq != `RCS_FREQ_ZERO);
    dec_dwell_ok = vf_mode && (dec_time != 10'h000) && (cfg.dec_dwell_freq != `RCS_FREQ_ZERO);
    running      = (state != RCS_IDLE) && (state != RCS_QSTOP) && (state != RCS_COAST);
  end

  // Sequencer state machine.
  always_comb
  begin
    next_state      = state;
    next_acc_spent  = acc_spent;
    next_need_fresh = need_fresh;
    next_acc_start  = 1'b0;
    next_dec_start  = 1'b0;
    if (!run_cmd)
      next_need_fresh = 1'b0;
    unique case (state)
      RCS_IDLE:
      begin
        if (!run_cmd)
          next_acc_spent = 1'b0;
        else if (enable_ok && !need_fresh)
        begin
          next_acc_spent = 1'b1;
          if (acc_dwell_ok && !acc_spent)
            next_state = RCS_ACC_RAMP;
          else
            next_state = RCS_RUN;
        end
      end
      RCS_ACC_RAMP:
      begin
        if (out_freq >= acc_freq)
        begin
          next_state     = RCS_ACC_HOLD;
          next_acc_start = 1'b1;
        end
      end
      RCS_ACC_HOLD:
      begin
        if (acc_done)
          next_state = RCS_RUN;
      end
      RCS_DEC_RAMP:
      begin
        if (run_cmd)
          next_state = RCS_RUN;
        else if (out_freq <= dec_freq)
        begin
          next_state     = RCS_DEC_HOLD;
          next_dec_start = 1'b1;
        end
      end
      RCS_DEC_HOLD:
      begin
        if (run_cmd)
          next_state = RCS_RUN;
        else if (dec_done)
          next_state = RCS_DECEL;
      end
      RCS_DECEL:
      begin
        if (run_cmd)
          next_state = RCS_RUN;
        else if (out_freq == `RCS_FREQ_ZERO)
          next_state = RCS_IDLE;
      end
      RCS_QSTOP:
      begin
        if (out_freq == `RCS_FREQ_ZERO)
          next_state = RCS_IDLE;
      end
      RCS_COAST:
      begin
        if (enable_ok)
          next_state = RCS_IDLE;
      end
      default:
      begin
        next_state = state;
      end
    endcase
    // Only a stop command takes the dwell path; the reference itself never does.
    if ((state == RCS_RUN || state == RCS_ACC_RAMP || state == RCS_ACC_HOLD) && !run_cmd)
      next_state = dec_dwell_ok ? RCS_DEC_RAMP : RCS_DECEL;
    // Loss of run-enable overrides every running state.
    if (running && !enable_ok)
    begin
      if (cfg.stop_mode == `RCS_STOP_FREE_RUN)
        next_state = RCS_COAST;
      else
        next_state = RCS_QSTOP;
      if (cfg.stop_mode != `RCS_STOP_QUICK_RESUME)
        next_need_fresh = 1'b1;
    end
  end

  // Registered status and reference follow the next state; decel_time clamps the quick-stop setting.
  always_comb
  begin
    next_status                   = '0;
    next_status.run_active        = (next_state != RCS_IDLE) && (next_state != RCS_COAST);
    next_status.reverse_dir       = (next_state == RCS_IDLE) ? want_rev : status.reverse_dir;
    next_status.output_block      = (next_state == RCS_COAST) || (next_state == RCS_IDLE);
    next_status.quick_stop_active = (next_state == RCS_QSTOP);
    next_status.acc_dwell_active  = (next_state == RCS_ACC_RAMP) || (next_state == RCS_ACC_HOLD);
    next_status.dec_dwell_active  = (next_state == RCS_DEC_RAMP) || (next_state == RCS_DEC_HOLD);
    next_status.need_fresh_cmd    = next_need_fresh;
    if (running && (next_state == RCS_RUN))
      next_status.reverse_dir = want_rev;
    unique case (next_state)
      RCS_ACC_RAMP,
      RCS_ACC_HOLD: next_freq_ref = acc_freq;
      RCS_DEC_RAMP,
      RCS_DEC_HOLD: next_freq_ref = dec_freq;
      RCS_RUN:      next_freq_ref = target_freq;
      default:      next_freq_ref = `RCS_FREQ_ZERO;
    endcase
    next_decel_time = (cfg.qstop_time > `RCS_QSTOP_TIME_MAX) ? `RCS_QSTOP_TIME_MAX : cfg.qstop_time;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fwd_d      <= 1'b0;
      rev_d      <= 1'b0;
      fwd_latch  <= 1'b0;
      rev_latch  <= 1'b0;
      state      <= RCS_IDLE;
      acc_spent  <= 1'b0;
      need_fresh <= 1'b0;
      acc_start  <= 1'b0;
      dec_start  <= 1'b0;
      status     <= '{output_block: 1'b1, default: 1'b0};
      freq_ref   <= `RCS_FREQ_ZERO;
      decel_time <= `RCS_QSTOP_TIME_RST;
    end
    else
    begin
      fwd_d      <= fwd_f;
      rev_d      <= rev_f;
      fwd_latch  <= next_fwd_latch;
      rev_latch  <= next_rev_latch;
      state      <= next_state;
      acc_spent  <= next_acc_spent;
      need_fresh <= next_need_fresh;
      acc_start  <= next_acc_start;
      dec_start  <= next_dec_start;
      status     <= next_status;
      freq_ref   <= next_freq_ref;
      decel_time <= next_decel_time;
    end
  end

endmodule

// >>> rcs_sequencer_chk.sv
// Checker for the run-command sequencer ports.
module rcs_sequencer_chk
  import rcs_pkg::*;
#(
  parameter int PRESS_CYCLES = 4,
  parameter int TENTH_CYCLES = 10
)
(
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst_b,
  // Terminals and settings.
  input wire logic        forward_run_cmd,
  input wire logic        reverse_run_cmd,
  input wire logic        stop_term,
  input wire logic        run_enable_term,
  input wire rcs_cfg_t    cfg,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] out_freq,
  // Results.
  input wire rcs_status_t status,
  input wire logic [15:0] freq_ref,
  input wire logic [12:0] decel_time
);
  timeunit 1ns;
  timeprecision 1ns;
  // Edges from a pin change until the outputs show it: two sync, the filter, one state edge, one spare.
  localparam int LAT = PRESS_CYCLES + 4;
  int en_low_cnt;
  int halt_cnt;
  int dwell_cnt;
  logic three_wire;
  assign three_wire = (cfg.stop_term_func == 6'h0E);

  function automatic logic [15:0] clampf(input logic [15:0] f);
    return (f < cfg.start_freq) ? cfg.start_freq : ((f > cfg.max_freq) ? cfg.max_freq : f);
  endfunction

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_low_cnt <= 0;
      halt_cnt <= 0;
      dwell_cnt <= 0;
    end
    else
    begin
      en_low_cnt <= run_enable_term ? 0 : en_low_cnt + 1;
      halt_cnt <= (three_wire && (!stop_term || (forward_run_cmd && reverse_run_cmd))) ? halt_cnt + 1 : 0;
      dwell_cnt <= status.acc_dwell_active ? dwell_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_dwell_on;
    $rose(status.acc_dwell_active);
  endsequence
  sequence s_dwell_end;
    $fell(status.acc_dwell_active) ##0 (status.run_active && freq_ref == target_freq);
  endsequence

  chk_idle_blocks: assert property (!status.run_active |-> status.output_block && freq_ref == 16'h0000)
    else $error("output not blocked while not running");
  chk_qstop_time: assert property ($past(rst_b) |->
    decel_time == (($past(cfg.qstop_time) > 13'h1770) ? 13'h1770 : $past(cfg.qstop_time)))
    else $error("quick-stop time wrong");
  chk_enable_gate: assert property (cfg.gating_by_input && en_low_cnt >= LAT |->
    ((cfg.stop_mode == 2'h0) ? (status.output_block && !status.run_active)
                             : (status.output_block || status.quick_stop_active)))
    else $error("running without enable");
  chk_stop_clears: assert property (halt_cnt >= LAT && !stop_term |->
    freq_ref == 16'h0000 || status.dec_dwell_active)
    else $error("stop terminal ignored");
  chk_both_stop: assert property (halt_cnt >= LAT && forward_run_cmd && reverse_run_cmd |->
    freq_ref == 16'h0000 || status.dec_dwell_active)
    else $error("both directions did not stop");
  chk_dwell_vf: assert property (cfg.control_mode != 3'h0 |->
    !status.acc_dwell_active && !status.dec_dwell_active)
    else $error("dwell outside V/F");
  chk_dwell_zero: assert property (cfg.acc_dwell_time == 10'h000 || cfg.acc_dwell_freq == 16'h0000 |->
    !status.acc_dwell_active)
    else $error("zero acc dwell not skipped");
  chk_dwell_ref: assert property (s_dwell_on |-> freq_ref == clampf(cfg.acc_dwell_freq))
    else $error("acc dwell reference wrong");
  chk_dec_ref: assert property (status.dec_dwell_active |-> freq_ref == clampf(cfg.dec_dwell_freq))
    else $error("dec dwell reference wrong");
  chk_dwell_hold: assert property (s_dwell_end |-> dwell_cnt >= cfg.acc_dwell_time * TENTH_CYCLES)
    else $error("acc dwell too short");
endmodule

bind rcs_sequencer rcs_sequencer_chk #(.PRESS_CYCLES(PRESS_CYCLES), .TENTH_CYCLES(TENTH_CYCLES)) chk_inst
  (.mclk(mclk), .rst_b(rst_b), .forward_run_cmd(forward_run_cmd), .reverse_run_cmd(reverse_run_cmd),
   .stop_term(stop_term), .run_enable_term(run_enable_term), .cfg(cfg), .target_freq(target_freq),
   .out_freq(out_freq), .status(status), .freq_ref(freq_ref), .decel_time(decel_time));

// >>> rcs_buttons.sv
// Push buttons and switches on the terminals, each press stretched to a minimum hold.
module rcs_buttons
#(
  parameter int HOLD = 8
)
(
  // Clock and press requests.
  input  wire logic mclk,
  input  wire logic fwd_req,
  input  wire logic rev_req,
  input  wire logic stop_req,
  input  wire logic en_req,
  // Terminal pins.
  output logic      forward_run_cmd,
  output logic      reverse_run_cmd,
  output logic      stop_term,
  output logic      run_enable_term
);
  timeunit 1ns;
  timeprecision 1ns;
  int fc = 0;
  int rc = 0;
  int sc = 0;
  // A press stays down for HOLD cycles after the request ends.
  // Counting on the rising edge keeps clear of the bench, which moves requests on the falling edge.
  always @(posedge mclk)
  begin
    fc <= fwd_req ? HOLD : ((fc > 0) ? fc - 1 : 0);
    rc <= rev_req ? HOLD : ((rc > 0) ? rc - 1 : 0);
    sc <= stop_req ? HOLD : ((sc > 0) ? sc - 1 : 0);
  end
  assign forward_run_cmd = fwd_req || (fc > 0);
  assign reverse_run_cmd = rev_req || (rc > 0);
  // The stop button is normally closed, so a press pulls the terminal low.
  assign stop_term = !(stop_req || (sc > 0));
  assign run_enable_term = en_req;
endmodule

// >>> drive_run_command_sequencer_test.sv
// Self-checking testbench for the run-command sequencer.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module drive_run_command_sequencer_test
  import rcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PRESS = 4;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        fwd_req = 1'b0;
  logic        rev_req = 1'b0;
  logic        stop_req = 1'b0;
  logic        en_req = 1'b0;
  logic        fwd_pin;
  logic        rev_pin;
  logic        stop_pin;
  logic        en_pin;
  rcs_cfg_t    cfg;
  logic [15:0] target_freq = 16'h00C8;
  logic [15:0] out_freq = 16'h0000;
  rcs_status_t status;
  logic [15:0] freq_ref;
  logic [12:0] decel_time;
  int          n_mismatch = 0;
  int          n_tests = 0;

  rcs_buttons #(.HOLD(PRESS + 4)) rcs_buttons_inst (.mclk(mclk), .fwd_req(fwd_req), .rev_req(rev_req),
    .stop_req(stop_req), .en_req(en_req), .forward_run_cmd(fwd_pin), .reverse_run_cmd(rev_pin),
    .stop_term(stop_pin), .run_enable_term(en_pin));
  rcs_sequencer #(.PRESS_CYCLES(PRESS), .TENTH_CYCLES(10)) rcs_sequencer_inst (.mclk(mclk), .rst_b(rst_b),
    .forward_run_cmd(fwd_pin), .reverse_run_cmd(rev_pin), .stop_term(stop_pin), .run_enable_term(en_pin),
    .cfg(cfg), .target_freq(target_freq), .out_freq(out_freq), .status(status), .freq_ref(freq_ref),
    .decel_time(decel_time));

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // The external ramp moves one step per cycle toward the reference.
  always @(negedge mclk)
  begin
    if (out_freq < freq_ref) out_freq <= out_freq + 16'h0001;
    else if (out_freq > freq_ref) out_freq <= out_freq - 16'h0001;
  end

  task automatic do_reset();
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  task automatic pulse(ref logic r);
    @(negedge mclk);
    r = 1'b1;
    @(negedge mclk);
    r = 1'b0;
    repeat (PRESS + 16) @(negedge mclk);
  endtask

  task automatic wait_idle();
    repeat (800) if (status.output_block !== 1'b1) @(negedge mclk);
  endtask

  task automatic t_three_wire();
    cfg.stop_term_func = 6'h0E;
    cfg.gating_by_input = 1'b0;
    en_req = 1'b0;
    do_reset();
    `CHK("decel_time", 13'h0032, decel_time)
    cfg.qstop_time = 13'h1FFF;
    repeat (2) @(negedge mclk);
    `CHK("qstop_clamp", 13'h1770, decel_time)
    cfg.qstop_time = 13'h0032;
    pulse(fwd_req);
    `CHK("run_latched", 1'b1, status.run_active)
    `CHK("freq_target", 16'h00C8, freq_ref)
    pulse(stop_req);
    `CHK("stop_ref", 16'h0000, freq_ref)
    wait_idle();
    `CHK("stopped", 1'b0, status.run_active)
    pulse(fwd_req);
    @(negedge mclk);
    fwd_req = 1'b1;
    rev_req = 1'b1;
    @(negedge mclk);
    fwd_req = 1'b0;
    rev_req = 1'b0;
    repeat (PRESS + 16) @(negedge mclk);
    `CHK("both_ref", 16'h0000, freq_ref)
    wait_idle();
    `CHK("both_stop", 1'b0, status.run_active)
    pulse(rev_req);
    `CHK("rev_dir", 1'b1, status.reverse_dir)
    pulse(stop_req);
    wait_idle();
    $display("test three_wire done");
  endtask

  task automatic t_gate(input logic [1:0] mode);
    cfg.stop_term_func = 6'h00;
    cfg.gating_by_input = 1'b1;
    cfg.stop_mode = mode;
    en_req = 1'b0;
    do_reset();
    fwd_req = 1'b1;
    repeat (30) @(negedge mclk);
    `CHK("gated_off", 1'b0, status.run_active)
    en_req = 1'b1;
    repeat (30) @(negedge mclk);
    `CHK("gated_on", 1'b1, status.run_active)
    en_req = 1'b0;
    repeat (PRESS + 16) @(negedge mclk);
    `CHK("block_out", (mode == 2'h0), status.output_block)
    `CHK("qstop_on", (mode != 2'h0), status.quick_stop_active)
    wait_idle();
    en_req = 1'b1;
    repeat (30) @(negedge mclk);
    `CHK("resume", (mode == 2'h2), status.run_active)
    `CHK("need_fresh", (mode != 2'h2), status.need_fresh_cmd)
    fwd_req = 1'b0;
    repeat (PRESS + 16) @(negedge mclk);
    fwd_req = 1'b1;
    repeat (30) @(negedge mclk);
    `CHK("fresh_run", 1'b1, status.run_active)
    fwd_req = 1'b0;
    wait_idle();
    $display("test gate mode %0d done", mode);
  endtask

  task automatic t_dwell(input logic [2:0] ctrl, input logic [9:0] tim);
    logic exp;
    exp = (ctrl == 3'h0) && (tim != 10'h000);
    cfg.stop_term_func = 6'h0E;
    cfg.gating_by_input = 1'b0;
    cfg.control_mode = ctrl;
    cfg.acc_dwell_time = tim;
    cfg.dec_dwell_time = tim;
    do_reset();
    pulse(fwd_req);
    `CHK("acc_dwell", exp, status.acc_dwell_active)
    `CHK("acc_ref", exp ? 16'h0064 : 16'h00C8, freq_ref)
    repeat (800) if (freq_ref !== 16'h00C8) @(negedge mclk);
    `CHK("after_dwell", 1'b0, status.acc_dwell_active)
    pulse(stop_req);
    `CHK("dec_dwell", exp, status.dec_dwell_active)
    `CHK("dec_ref", exp ? 16'h0064 : 16'h0000, freq_ref)
    wait_idle();
    `CHK("dwell_stop", 1'b0, status.run_active)
    $display("test dwell ctrl %0d time %0d done", ctrl, tim);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    cfg = '{stop_term_func: 6'h0E, run_en_term_func: 6'h0D, gating_by_input: 1'b0, stop_mode: 2'h0,
            control_mode: 3'h0, acc_dwell_freq: 16'h0064, acc_dwell_time: 10'h000,
            dec_dwell_freq: 16'h0064, dec_dwell_time: 10'h000, start_freq: 16'h0032,
            max_freq: 16'h1770, qstop_time: 13'h0032};
    t_three_wire();
    for (int m = 0; m < 3; m++) t_gate(m[1:0]);
    t_dwell(3'h0, 10'h002);
    t_dwell(3'h1, 10'h002);
    t_dwell(3'h0, 10'h000);
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
